// >>> rvps_pkg.sv
// Purpose: shared constants and types of the voltage protection stage
// Assumes: one 40 MHz clock, voltages in steps of 0.01 percent of nominal
// Notes: times are counted in 5 ms steps throughout
`default_nettype none
package rvps_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_NS      = 25;
	localparam int unsigned STEP_NS     = 5000000;
	localparam int unsigned TICK_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          AW          = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_PICKUP = 8'h04;
	localparam logic [7:0]  ADDR_BLOCK  = 8'h08;
	localparam logic [7:0]  ADDR_PULSE  = 8'h0C;
	localparam logic [7:0]  ADDR_DELAY  = 8'h10;
	localparam logic [7:0]  ADDR_STATUS = 8'h14;
	localparam logic [7:0]  ADDR_REMAIN = 8'h18;
	localparam logic [7:0]  ADDR_EXPECT = 8'h1C;
	localparam logic [7:0]  ADDR_RATIO  = 8'h20;
	localparam logic [7:0]  ADDR_PU     = 8'h24;
	// Control fields
	localparam int          CTRL_FORCE  = 0;
	localparam int          CTRL_CHAN   = 2;
	localparam int          CTRL_UNDER  = 4;
	localparam int          CTRL_PERM   = 5;
	localparam logic [5:0]  CTRL_RST    = 6'h00;
	// ----------------------------------------------------------------
	// Settings limits and resets
	// ----------------------------------------------------------------
	localparam logic [13:0] PICKUP_RST  = 14'h07D0;
	localparam logic [13:0] PICKUP_MAX  = 14'h3A98;
	localparam logic [13:0] BLOCK_RST   = 14'h0000;
	localparam logic [13:0] BLOCK_MAX   = 14'h1F40;
	localparam logic [18:0] PULSE_RST   = 19'h00014;
	localparam logic [18:0] DELAY_RST   = 19'h00008;
	localparam logic [18:0] TIME_MAX    = 19'h57E40;
	localparam logic [23:0] HYST_OVER   = 24'h000061;
	localparam logic [23:0] HYST_UNDER  = 24'h000067;
	localparam logic [23:0] PERCENT     = 24'h000064;
	localparam logic [23:0] RATIO_MAX   = 24'h01E848;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} rvps_cond_type;
	typedef enum logic [1:0] {DIV_IDLE, DIV_RATIO, DIV_PU} rvps_div_type;
endpackage : rvps_pkg
`default_nettype wire

// >>> rvps_div.sv
// Purpose: restoring divider, one quotient bit per clock
// Assumes: start is ignored while busy
// Notes: a zero divisor gives an all-ones quotient
`default_nettype none
module rvps_div (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        start,
	input  wire logic [23:0] num,
	input  wire logic [15:0] den,
	output logic             done,
	output logic [23:0]      quo
);
	logic [23:0] quo_q, quo_d;
	logic [15:0] rem_q, rem_d, den_q, den_d;
	logic [4:0]  cnt_q, cnt_d;
	logic        busy_q, busy_d, done_q, done_d;
	logic [17:0] trial;

	always_comb begin
		quo_d  = quo_q;
		rem_d  = rem_q;
		den_d  = den_q;
		cnt_d  = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		trial  = {1'b0, rem_q, quo_q[23]} - {2'b00, den_q};
		if (start && !busy_q) begin
			quo_d  = num;
			rem_d  = 16'h0000;
			den_d  = den;
			cnt_d  = 5'h00;
			busy_d = 1'b1;
		end else if (busy_q) begin
			quo_d = {quo_q[22:0], !trial[17]};
			rem_d = trial[17] ? {rem_q[14:0], quo_q[23]} : trial[15:0];
			cnt_d = cnt_q + 5'h01;
			if (cnt_q == 5'h17) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			quo_q  <= 24'h000000;
			rem_q  <= 16'h0000;
			den_q  <= 16'h0000;
			cnt_q  <= 5'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			quo_q  <= quo_d;
			rem_q  <= rem_d;
			den_q  <= den_d;
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
	assign quo  = quo_q;

	done_single_a: assert property (@(posedge aclk) disable iff (!aresetn) done_q |=> !done_q)
		else $error("divider done longer than one cycle");
endmodule : rvps_div
`default_nettype wire

// >>> rvps_pulse.sv
// Purpose: trip pulse of a set number of 5 ms steps
// Assumes: load is a one-cycle pulse
// Notes: own step prescaler restarts on load, so length is exact
`default_nettype none
module rvps_pulse #(
	parameter int unsigned TICK_CYCLES = rvps_pkg::TICK_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        load,
	input  wire logic [18:0] len,
	output logic             active
);
	logic [18:0] cnt_q, cnt_d;
	logic [17:0] pre_q, pre_d;
	logic        act_q, act_d;

	always_comb begin
		cnt_d = cnt_q;
		pre_d = pre_q + 18'h00001;
		if (load) begin
			cnt_d = len;
			pre_d = 18'h00000;
		end else if (pre_q == 18'(TICK_CYCLES - 1)) begin
			pre_d = 18'h00000;
			if (cnt_q != 19'h00000) begin
				cnt_d = cnt_q - 19'h00001;
			end
		end
		act_d = (cnt_d != 19'h00000);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 19'h00000;
			pre_q <= 18'h00000;
			act_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			pre_q <= pre_d;
			act_q <= act_d;
		end
	end

	assign active = act_q;

	pulse_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		load && len != 19'h00000 |=> active)
		else $error("trip pulse did not start");
endmodule : rvps_pulse
`default_nettype wire

// >>> rvps_stage.sv
// Purpose: one over/undervoltage protection stage with AXI4-Lite settings
// Assumes: rms inputs in 0.01 %Un steps; meas_valid pulses once per update
// Notes: operating delay is definite time only
//
// How it works
// - Software may force status start, trip or blocked when permitted.
// - One of four voltage channels is monitored, first channel by default.
// - Force and channel selectors sit in a static control register.
// - Overvoltage releases only below 97 percent of pick-up level.
// - Undervoltage releases only above 103 percent of pick-up level.
// - Mode bit picks up above level (over, default) or below (under).
// - Pick-up level up to 150 percent in 0.01 percent steps, default 20.
// - Block level up to 80 percent, under mode only, zero disables it.
// - Below block level tripping is held off until all channels reach pick-up.
// - Trip fires a pulse of up to 1800 s in 5 ms steps, default 100 ms.
// - Group settings apply at once while the stage runs.
// - Block level is advised in under mode against dead-network trips.
// - Condition readback shows normal, start, trip or blocked.
// - Remaining time to trip is readable in 5 ms steps.
// - Expected operating time is readable.
// - Ratio of voltage to pick-up level readable in 0.01 steps, to 1250.
// - Measured voltage readable in per unit, 0.01 steps.
// - Only RMS values are compared, refreshed each 5 ms.
// - Blocking input at pick-up gives blocked; an active start is dropped.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module rvps_stage #(
	parameter int unsigned TICK_CYCLES = rvps_pkg::TICK_CYCLES
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [rvps_pkg::AW-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [rvps_pkg::AW-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic [15:0]             rms_0,
	input  wire logic [15:0]             rms_1,
	input  wire logic [15:0]             rms_2,
	input  wire logic [15:0]             rms_3,
	input  wire logic                    meas_valid,
	input  wire logic                    block_in,
	output logic                         start_out,
	output logic                         trip_out,
	output logic                         blocked_out,
	output logic                         trip_pulse_out
);
	import rvps_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [5:0]    ctrl_q, ctrl_d;
	logic [13:0]   pick_q, pick_d, blk_q, blk_d;
	logic [18:0]   pulse_q, pulse_d, delay_q, delay_d, remain_q, remain_d;
	logic          bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]   rdata_q, rdata_d;
	logic          wr_go, rd_go;
	rvps_cond_type st_q, st_d, eff, eff_q;
	logic          picked_q, picked_d, uvblk_q, uvblk_d, pick_raw;
	logic [17:0]   tick_q, tick_d;
	logic          tick, forcing, under;
	logic [15:0]   v;
	logic [23:0]   v100, p97, p103;
	logic          all_up;
	rvps_div_type  dst_q, dst_d;
	logic [15:0]   vlat_q, vlat_d, pu_q, pu_d;
	logic [23:0]   ratio_q, ratio_d, div_num, div_quo;
	logic [15:0]   div_den;
	logic          div_start, div_done, pulse_act;

	function automatic logic [31:0] rvps_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : rvps_merge

	function automatic logic [18:0] rvps_clamp(input logic [31:0] x, input logic [18:0] mx);
		return (x > {13'h0000, mx}) ? mx : x[18:0];
	endfunction : rvps_clamp

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// Address and data are taken together; no skid buffer is needed then
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign rd_go         = s_axi_arvalid && !rvalid_q;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;

	always_comb begin
		logic [31:0] wv;
		wv       = 32'h00000000;
		ctrl_d   = ctrl_q;
		pick_d   = pick_q;
		blk_d    = blk_q;
		pulse_d  = pulse_q;
		delay_d  = delay_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d  = bresp_q;
		if (wr_go) begin
			bvalid_d = 1'b1;
			bresp_d  = RESP_OKAY;
			case (s_axi_awaddr)
				ADDR_CTRL: begin
					wv     = rvps_merge({26'h0000000, ctrl_q}, s_axi_wdata, s_axi_wstrb);
					ctrl_d = wv[5:0];
				end
				ADDR_PICKUP: begin
					wv     = rvps_merge({18'h00000, pick_q}, s_axi_wdata, s_axi_wstrb);
					pick_d = 14'(rvps_clamp(wv, {5'h00, PICKUP_MAX}));
				end
				ADDR_BLOCK: begin
					wv    = rvps_merge({18'h00000, blk_q}, s_axi_wdata, s_axi_wstrb);
					blk_d = 14'(rvps_clamp(wv, {5'h00, BLOCK_MAX}));
				end
				ADDR_PULSE: begin
					wv      = rvps_merge({13'h0000, pulse_q}, s_axi_wdata, s_axi_wstrb);
					pulse_d = rvps_clamp(wv, TIME_MAX);
				end
				ADDR_DELAY: begin
					wv      = rvps_merge({13'h0000, delay_q}, s_axi_wdata, s_axi_wstrb);
					delay_d = rvps_clamp(wv, TIME_MAX);
				end
				default: bresp_d = RESP_SLVERR;
			endcase
		end
	end

	always_comb begin
		rvalid_d = rvalid_q && !s_axi_rready;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			rdata_d  = 32'h00000000;
			case (s_axi_araddr)
				ADDR_CTRL:   rdata_d = {26'h0000000, ctrl_q};
				ADDR_PICKUP: rdata_d = {18'h00000, pick_q};
				ADDR_BLOCK:  rdata_d = {18'h00000, blk_q};
				ADDR_PULSE:  rdata_d = {13'h0000, pulse_q};
				ADDR_DELAY:  rdata_d = {13'h0000, delay_q};
				ADDR_STATUS: rdata_d = {27'h0000000, pulse_act, picked_q, uvblk_q, eff_q};
				ADDR_REMAIN: rdata_d = {13'h0000, remain_q};
				ADDR_EXPECT: rdata_d = {13'h0000, delay_q};
				ADDR_RATIO:  rdata_d = {8'h00, ratio_q};
				ADDR_PU:     rdata_d = {16'h0000, pu_q};
				default:     rresp_d = RESP_SLVERR;
			endcase
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp  = rresp_q;
	assign s_axi_rdata  = rdata_q;

	// ----------------------------------------------------------------
	// Comparisons
	// ----------------------------------------------------------------
	assign under   = ctrl_q[CTRL_UNDER];
	assign forcing = ctrl_q[CTRL_PERM] && ctrl_q[CTRL_FORCE +: 2] != 2'h0;

	always_comb begin
		case (ctrl_q[CTRL_CHAN +: 2])
			2'h0:    v = rms_0;
			2'h1:    v = rms_1;
			2'h2:    v = rms_2;
			default: v = rms_3;
		endcase
	end

	assign v100   = 24'(v) * PERCENT;
	assign p97    = 24'(pick_q) * HYST_OVER;
	assign p103   = 24'(pick_q) * HYST_UNDER;
	assign all_up = rms_0 >= 16'(pick_q) && rms_1 >= 16'(pick_q)
		&& rms_2 >= 16'(pick_q) && rms_3 >= 16'(pick_q);

	always_comb begin
		if (under) begin
			pick_raw = picked_q ? (v100 <= p103) : (v < 16'(pick_q));
		end else begin
			pick_raw = picked_q ? (v100 >= p97) : (v > 16'(pick_q));
		end
	end

	// ----------------------------------------------------------------
	// Stage state
	// ----------------------------------------------------------------
	assign tick = tick_q == 18'(TICK_CYCLES - 1);

	always_comb begin
		st_d     = st_q;
		picked_d = picked_q;
		uvblk_d  = uvblk_q;
		remain_d = remain_q;
		tick_d   = tick ? 18'h00000 : tick_q + 18'h00001;
		if (!under || blk_q == 14'h0000) begin
			uvblk_d = 1'b0;
		end else if (meas_valid && v < 16'(blk_q)) begin
			uvblk_d = 1'b1;
		end else if (meas_valid && all_up) begin
			uvblk_d = 1'b0;
		end
		if (meas_valid) begin
			picked_d = pick_raw;
			case (st_q)
				COND_NORMAL: begin
					if (pick_raw) begin
						st_d     = block_in ? COND_BLOCKED : COND_START;
						remain_d = delay_q;
						tick_d   = 18'h00000;
					end
				end
				COND_BLOCKED: begin
					if (!pick_raw) begin
						st_d = COND_NORMAL;
					end else if (!block_in) begin
						st_d     = COND_START;
						remain_d = delay_q;
						tick_d   = 18'h00000;
					end
				end
				COND_START, COND_TRIP: begin
					if (!pick_raw) begin
						st_d = COND_NORMAL;
					end else if (block_in) begin
						st_d = COND_BLOCKED;
					end
				end
				default: st_d = COND_NORMAL;
			endcase
		end
		// Countdown pauses while the dead-network block holds; it also runs in update
		// cycles, since updates and steps share one period and would otherwise collide
		if (st_q == COND_START && st_d == COND_START && !uvblk_q) begin
			if (remain_q == 19'h00000) begin
				st_d = COND_TRIP;
			end else if (tick) begin
				remain_d = remain_q - 19'h00001;
			end
		end
		if (st_d != COND_START) begin
			remain_d = 19'h00000;
		end
	end

	always_comb begin
		eff = forcing ? rvps_cond_type'(ctrl_q[CTRL_FORCE +: 2]) : st_q;
	end

	assign start_out   = eff_q == COND_START || eff_q == COND_TRIP;
	assign trip_out    = eff_q == COND_TRIP;
	assign blocked_out = eff_q == COND_BLOCKED;

	rvps_pulse #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_pulse (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (eff == COND_TRIP && eff_q != COND_TRIP),
		.len     (pulse_q),
		.active  (pulse_act)
	);
	assign trip_pulse_out = pulse_act;

	// ----------------------------------------------------------------
	// Ratio and per-unit readback
	// ----------------------------------------------------------------
	always_comb begin
		dst_d     = dst_q;
		vlat_d    = vlat_q;
		ratio_d   = ratio_q;
		pu_d      = pu_q;
		div_start = 1'b0;
		div_num   = 24'(vlat_q);
		div_den   = 16'(PERCENT);
		case (dst_q)
			DIV_IDLE: begin
				div_num = v100;
				div_den = 16'(pick_q);
				if (meas_valid) begin
					vlat_d    = v;
					div_start = 1'b1;
					dst_d     = DIV_RATIO;
				end
			end
			DIV_RATIO: begin
				if (div_done) begin
					ratio_d   = (div_quo > RATIO_MAX) ? RATIO_MAX : div_quo;
					div_start = 1'b1;
					dst_d     = DIV_PU;
				end
			end
			DIV_PU: begin
				if (div_done) begin
					pu_d  = div_quo[15:0];
					dst_d = DIV_IDLE;
				end
			end
			default: dst_d = DIV_IDLE;
		endcase
	end

	rvps_div u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (div_start),
		.num     (div_num),
		.den     (div_den),
		.done    (div_done),
		.quo     (div_quo)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q   <= CTRL_RST;
			pick_q   <= PICKUP_RST;
			blk_q    <= BLOCK_RST;
			pulse_q  <= PULSE_RST;
			delay_q  <= DELAY_RST;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h00000000;
			st_q     <= COND_NORMAL;
			eff_q    <= COND_NORMAL;
			picked_q <= 1'b0;
			uvblk_q  <= 1'b0;
			remain_q <= 19'h00000;
			tick_q   <= 18'h00000;
			dst_q    <= DIV_IDLE;
			vlat_q   <= 16'h0000;
			ratio_q  <= 24'h000000;
			pu_q     <= 16'h0000;
		end else begin
			ctrl_q   <= ctrl_d;
			pick_q   <= pick_d;
			blk_q    <= blk_d;
			pulse_q  <= pulse_d;
			delay_q  <= delay_d;
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q  <= rresp_d;
			rdata_q  <= rdata_d;
			st_q     <= st_d;
			eff_q    <= eff;
			picked_q <= picked_d;
			uvblk_q  <= uvblk_d;
			remain_q <= remain_d;
			tick_q   <= tick_d;
			dst_q    <= dst_d;
			vlat_q   <= vlat_d;
			ratio_q  <= ratio_d;
			pu_q     <= pu_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_trip_entry;
		eff == COND_TRIP && eff_q != COND_TRIP && pulse_q > 19'h00001;
	endsequence
	sequence s_pulse_held;
		##1 trip_pulse_out [*2];
	endsequence

	force_trip_a: assert property (ctrl_q[CTRL_PERM] && ctrl_q[CTRL_FORCE +: 2] == 2'h2 |=> trip_out)
		else $error("forced trip not shown");
	over_hold_a: assert property (meas_valid && !under && picked_q && v100 >= p97 |=> picked_q)
		else $error("overvoltage released above hysteresis");
	under_rel_a: assert property (meas_valid && under && picked_q && v100 > p103 |=> !picked_q)
		else $error("undervoltage not released");
	uv_hold_a: assert property (!meas_valid && uvblk_q && st_q == COND_START |=> st_q != COND_TRIP)
		else $error("trip while undervoltage block active");
	blk_zero_a: assert property (blk_q == 14'h0000 |=> !uvblk_q)
		else $error("block active with zero level");
	start_drop_a: assert property (meas_valid && st_q == COND_START && pick_raw && block_in
		|=> st_q == COND_BLOCKED)
		else $error("start not dropped on blocking");
	pulse_len_a: assert property (s_trip_entry |-> s_pulse_held)
		else $error("trip pulse too short");
	update_only_a: assert property (!meas_valid |=> $stable(picked_q))
		else $error("pick-up changed outside update");
	write_resp_a: assert property (wr_go |=> s_axi_bvalid ##0 ($past(s_axi_awaddr) != ADDR_CTRL
		|| !$past(s_axi_wstrb[0]) || ctrl_q == $past(s_axi_wdata[5:0])))
		else $error("write response missing");
endmodule : rvps_stage
`default_nettype wire

// >>> rvps_tb.sv
// Purpose: self-checking testbench of the voltage protection stage
// Assumes: step prescaler shortened to 4 cycles, so one 5 ms step lasts 4 clocks
// Notes: bus answers are sampled at the falling edge, where registered outputs are settled
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rvps_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int unsigned TICKS = 4;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awa;
	logic [7:0]  ara;
	logic [31:0] wd;
	logic        awv;
	logic        wv;
	logic        bready;
	logic        arv;
	logic        rready;
	logic [15:0] v [4];
	logic        mv;
	logic        blk;
	logic        awrdy;
	logic        wrdy;
	logic        bv;
	logic        arrdy;
	logic        rv;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [31:0] rdata;
	logic        st;
	logic        tr;
	logic        bl;
	logic        tp;
	logic [31:0] rdv;
	logic [1:0]  rsp;
	int          fails;
	int          cmp_count;
	int          pcnt;
	// Reset readback rows: response, address, expected data
	localparam logic [41:0] ROWS [10] = '{
		{RESP_OKAY, ADDR_CTRL, 32'h00000000}, {RESP_OKAY, ADDR_PICKUP, 32'h000007D0},
		{RESP_OKAY, ADDR_BLOCK, 32'h00000000}, {RESP_OKAY, ADDR_PULSE, 32'h00000014},
		{RESP_OKAY, ADDR_DELAY, 32'h00000008}, {RESP_OKAY, ADDR_STATUS, 32'h00000000},
		{RESP_OKAY, ADDR_REMAIN, 32'h00000000}, {RESP_OKAY, ADDR_EXPECT, 32'h00000008},
		{RESP_SLVERR, 8'h28, 32'h00000000}, {RESP_SLVERR, 8'hFC, 32'h00000000}};
	rvps_stage #(.TICK_CYCLES(TICKS)) uut (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awa),
		.s_axi_awvalid (awv),
		.s_axi_awready (awrdy),
		.s_axi_wdata   (wd),
		.s_axi_wstrb   (4'hF),
		.s_axi_wvalid  (wv),
		.s_axi_wready  (wrdy),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bv),
		.s_axi_bready  (bready),
		.s_axi_araddr  (ara),
		.s_axi_arvalid (arv),
		.s_axi_arready (arrdy),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rv),
		.s_axi_rready  (rready),
		.rms_0         (v[0]),
		.rms_1         (v[1]),
		.rms_2         (v[2]),
		.rms_3         (v[3]),
		.meas_valid    (mv),
		.block_in      (blk),
		.start_out     (st),
		.trip_out      (tr),
		.blocked_out   (bl),
		.trip_pulse_out(tp)
	);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Address and data offered together; released only after the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do @(negedge aclk); while (awrdy !== 1'b1 || wrdy !== 1'b1);
		@(posedge aclk);
		awv <= 1'b0;
		wv <= 1'b0;
		do @(negedge aclk); while (bv !== 1'b1);
		rsp = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arrdy !== 1'b1);
		@(posedge aclk);
		arv <= 1'b0;
		do @(negedge aclk); while (rv !== 1'b1);
		rdv = rdata;
		rsp = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd
	// One update, then 60 clocks so the readback dividers finish; counts pulse clocks
	task automatic meas(input logic [63:0] x, input logic b);
		@(posedge aclk);
		{v[3], v[2], v[1], v[0]} <= x;
		blk <= b;
		mv <= 1'b1;
		@(posedge aclk);
		mv <= 1'b0;
		pcnt = 0;
		repeat (60) begin
			@(negedge aclk);
			if (tp === 1'b1) pcnt++;
		end
	endtask : meas
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	// ----------------------------------------------------------------
	// Clock, watchdog and sequence
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// The sequence needs about 1000 clocks; a hang beyond 6000 is cut short
	initial begin
		repeat (6000) @(posedge aclk);
		fails++;
		stop_test();
	end
	initial begin
		{aresetn, awv, wv, bready, arv, rready, mv, blk} = '0;
		{awa, ara, wd} = '0;
		{v[3], v[2], v[1], v[0]} = '0;
		{fails, cmp_count, pcnt} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({28'h0, st, tr, bl, tp}, 32'h0);
		foreach (ROWS[i]) begin
			rd(ROWS[i][39:32]);
			chk(rdv, ROWS[i][31:0]);
			chk({30'h0, rsp}, {30'h0, ROWS[i][41:40]});
		end
		wr(ADDR_PICKUP, 32'h0000FFFF);
		chk({30'h0, rsp}, {30'h0, RESP_OKAY});
		rd(ADDR_PICKUP);
		chk(rdv, 32'h00003A98);
		wr(ADDR_BLOCK, 32'h0000FFFF);
		rd(ADDR_BLOCK);
		chk(rdv, 32'h00001F40);
		wr(ADDR_STATUS, 32'h0000001F);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(ADDR_PICKUP, 32'h00002710);
		wr(ADDR_DELAY, 32'h00000002);
		wr(ADDR_PULSE, 32'h00000003);
		meas({4{16'h2904}}, 1'b0);
		chk({31'h0, tr}, 32'h1);
		chk(pcnt, 3 * TICKS);
		rd(ADDR_STATUS);
		chk({30'h0, rdv[1:0]}, 32'h2);
		rd(ADDR_RATIO);
		chk(rdv, 32'h00000069);
		rd(ADDR_PU);
		chk(rdv, 32'h00000069);
		meas({4{16'h2648}}, 1'b0);
		chk({31'h0, st}, 32'h1);
		meas({4{16'h2580}}, 1'b0);
		chk({31'h0, st}, 32'h0);
		wr(ADDR_CTRL, 32'h00000008);
		rd(ADDR_CTRL);
		chk(rdv, 32'h00000008);
		meas({16'h0, 16'h2904, 16'h0, 16'h0}, 1'b0);
		chk({31'h0, st}, 32'h1);
		meas({16'h2904, 16'h0, 16'h2904, 16'h2904}, 1'b0);
		chk({31'h0, st}, 32'h0);
		meas({4{16'h2904}}, 1'b1);
		chk({30'h0, bl, st}, 32'h2);
		meas(64'h0, 1'b0);
		// Under mode with block level: dead network must not trip
		wr(ADDR_CTRL, 32'h00000010);
		wr(ADDR_PICKUP, 32'h00001388);
		wr(ADDR_BLOCK, 32'h000007D0);
		meas({4{16'h03E8}}, 1'b0);
		rd(ADDR_STATUS);
		chk({31'h0, rdv[2]}, 32'h1);
		chk({31'h0, tr}, 32'h0);
		rd(ADDR_REMAIN);
		chk(rdv, 32'h00000002);
		// Blocking arrives during a start: the start is dropped
		meas({4{16'h0FA0}}, 1'b1);
		chk({29'h0, bl, st, tr}, 32'h4);
		meas({4{16'h1770}}, 1'b0);
		rd(ADDR_STATUS);
		chk({31'h0, rdv[2]}, 32'h0);
		meas({4{16'h0FA0}}, 1'b0);
		chk({31'h0, tr}, 32'h1);
		meas({4{16'h13EC}}, 1'b0);
		chk({31'h0, st}, 32'h1);
		meas({4{16'h1450}}, 1'b0);
		chk({31'h0, st}, 32'h0);
		// Forcing acts only with the permission bit set
		wr(ADDR_CTRL, 32'h00000022);
		repeat (4) @(negedge aclk);
		chk({31'h0, tr}, 32'h1);
		wr(ADDR_CTRL, 32'h00000023);
		repeat (4) @(negedge aclk);
		chk({30'h0, bl, tr}, 32'h2);
		wr(ADDR_CTRL, 32'h00000002);
		repeat (4) @(negedge aclk);
		chk({29'h0, st, tr, bl}, 32'h0);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
